// [hdl/hrie_pkg.sv]
/*
 * Package for the third receive data-link interrupt block: register
 * indices and byte addresses, field positions, reset values, HDLC
 * constants and the carrier struct of the receive path.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package hrie_pkg;

	// ----------------------------------------------------------------
	// Register map: printed index, byte address is four times it
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_DL_STAT  = 12'hB26;
	localparam logic [11:0] IDX_DL_EN    = 12'hB27;
	localparam logic [11:0] IDX_OVR_STAT = 12'hB28;
	localparam logic [11:0] IDX_OVR_EN   = 12'hB29;
	localparam logic [13:0] ADDR_DL_STAT  = {IDX_DL_STAT, 2'b00};
	localparam logic [13:0] ADDR_DL_EN    = {IDX_DL_EN, 2'b00};
	localparam logic [13:0] ADDR_OVR_STAT = {IDX_OVR_STAT, 2'b00};
	localparam logic [13:0] ADDR_OVR_EN   = {IDX_OVR_EN, 2'b00};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          BIT_CHECK_ERR = 2;
	localparam int          BIT_ABORT     = 1;
	localparam int          BIT_FLAG      = 0;
	localparam int          BIT_OVERSIZE  = 0;
	localparam logic [2:0]  DL_RST        = 3'h0;
	localparam logic        OVR_RST       = 1'b0;

	// ----------------------------------------------------------------
	// HDLC receive constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  FLAG_OCTET    = 8'h7E;
	localparam logic [2:0]  ABORT_ONES    = 3'h7;
	localparam logic [8:0]  MAX_MSG_BYTES = 9'h114;

	// Receive data-link path, one clock domain with the register port
	typedef struct packed {
		logic dl_bit;       // Serial data-link bit
		logic dl_valid;     // Qualifies dl_bit
		logic byte_stb;     // One message byte received
		logic check_err;    // Frame check error on the last message
	} hrie_rx_t;

endpackage

// [hdl/hrie_irq.sv]
/*
 * Interrupt enable and status logic of the third receive data-link
 * controller: frame check error, abort, flag octet and oversize
 * message flags, their enables, one level interrupt and an
 * Avalon-MM register slave with waitrequest.
 * Assumes the receive path runs on mclk and a master that holds its
 * request until it samples waitrequest low.
 */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps

// Behaviour
// - Check error raises interrupt when enabled
// - Seven ones abort raises interrupt when enabled
// - Flag octet 0x7E raises interrupt when enabled
// - Oversize flag sets beyond 276 message bytes
// - Oversize flag holds until read, read clears
// - Oversize enable gates oversize interrupt
// - Data-link flags latch, cleared on status read
module hrie_irq (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [13:0]       avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire hrie_pkg::hrie_rx_t rx,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [2:0]  dl_stat_q;
	logic [2:0]  dl_stat_d;
	logic [2:0]  dl_en_q;
	logic [2:0]  dl_en_d;
	logic        ovr_stat_q;
	logic        ovr_stat_d;
	logic        ovr_en_q;
	logic        ovr_en_d;
	logic [7:0]  shift_q;
	logic [7:0]  shift_d;
	logic [2:0]  ones_q;
	logic [8:0]  count_q;
	logic        flag_ev;
	logic        abort_ev;
	logic        ovr_ev;
	logic [2:0]  dl_ev;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [2:0]  dl_seen_q;
	logic        ovr_seen_q;
	logic        irq_q;
	logic        req;
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------

	// A request is taken only on the edge where waitrequest is low
	assign req    = avs_read | avs_write;
	assign acc    = req & ~wait_q;
	assign wr_acc = acc & avs_write & avs_byteenable[0];
	assign rd_acc = acc & avs_read;

	// Waitrequest drops for one cycle after a request is seen
	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else if (req && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Read data is caught with the flag values that will be cleared,
	// so an event arriving after the capture is never lost
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q    <= 32'h0000_0000;
			dl_seen_q  <= 3'h0;
			ovr_seen_q <= 1'b0;
		end else if (req && wait_q) begin
			rdata_q    <= 32'h0000_0000;
			dl_seen_q  <= 3'h0;
			ovr_seen_q <= 1'b0;
			if (avs_read) begin
				case (avs_address)
				hrie_pkg::ADDR_DL_STAT: begin
					rdata_q[2:0] <= dl_stat_q;
					dl_seen_q    <= dl_stat_q;
				end
				hrie_pkg::ADDR_DL_EN: begin
					rdata_q[2:0] <= dl_en_q;
				end
				hrie_pkg::ADDR_OVR_STAT: begin
					rdata_q[0] <= ovr_stat_q;
					ovr_seen_q <= ovr_stat_q;
				end
				hrie_pkg::ADDR_OVR_EN: begin
					rdata_q[0] <= ovr_en_q;
				end
				default: begin
					rdata_q <= 32'h0000_0000; // Unmapped reads zero
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Flag octet and abort detection on the serial channel
	// ----------------------------------------------------------------

	// Bits enter at the top; the flag pattern is symmetric anyway
	assign shift_d = rx.dl_valid ? {rx.dl_bit, shift_q[7:1]} : shift_q;
	assign flag_ev = rx.dl_valid && (shift_d == hrie_pkg::FLAG_OCTET);

	// Abort fires once, on the seventh one in a row
	assign abort_ev = rx.dl_valid && rx.dl_bit &&
		(ones_q == hrie_pkg::ABORT_ONES - 3'h1);

	// Shift register of the last eight channel bits
	always_ff @(posedge mclk) begin
		if (rst) begin
			shift_q <= 8'h00;
		end else begin
			shift_q <= shift_d;
		end
	end

	// Run of ones, saturating so a long idle-ones line fires only once
	always_ff @(posedge mclk) begin
		if (rst) begin
			ones_q <= 3'h0;
		end else if (rx.dl_valid) begin
			if (!rx.dl_bit) begin
				ones_q <= 3'h0;
			end else if (ones_q != hrie_pkg::ABORT_ONES) begin
				ones_q <= ones_q + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Oversize message counter
	// ----------------------------------------------------------------

	// A flag closes the message; the count saturates one past the limit
	assign ovr_ev = rx.byte_stb && (count_q == hrie_pkg::MAX_MSG_BYTES);

	// Bytes since the last flag octet
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_q <= 9'h000;
		end else if (flag_ev) begin
			count_q <= 9'h000;
		end else if (rx.byte_stb &&
			count_q <= hrie_pkg::MAX_MSG_BYTES) begin
			count_q <= count_q + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// Status flags and enables
	// ----------------------------------------------------------------

	// Events gathered into the status layout
	always_comb begin
		dl_ev                          = 3'h0;
		dl_ev[hrie_pkg::BIT_CHECK_ERR] = rx.check_err;
		dl_ev[hrie_pkg::BIT_ABORT]     = abort_ev;
		dl_ev[hrie_pkg::BIT_FLAG]      = flag_ev;
	end

	// Read clears only what was reported; a new event wins the clear
	always_comb begin
		dl_stat_d  = dl_stat_q | dl_ev;
		ovr_stat_d = ovr_stat_q | ovr_ev;
		if (rd_acc && avs_address == hrie_pkg::ADDR_DL_STAT) begin
			dl_stat_d = (dl_stat_q & ~dl_seen_q) | dl_ev;
		end
		if (rd_acc && avs_address == hrie_pkg::ADDR_OVR_STAT) begin
			ovr_stat_d = (ovr_stat_q & ~ovr_seen_q) | ovr_ev;
		end
	end

	// Enables written through the low byte only; bits 6:3 of the
	// data-link enable belong to other interrupts and read as zero
	always_comb begin
		dl_en_d  = dl_en_q;
		ovr_en_d = ovr_en_q;
		if (wr_acc && avs_address == hrie_pkg::ADDR_DL_EN) begin
			dl_en_d = avs_writedata[2:0];
		end
		if (wr_acc && avs_address == hrie_pkg::ADDR_OVR_EN) begin
			ovr_en_d = avs_writedata[hrie_pkg::BIT_OVERSIZE];
		end
	end

	// Status flags
	always_ff @(posedge mclk) begin
		if (rst) begin
			dl_stat_q  <= hrie_pkg::DL_RST;
			ovr_stat_q <= hrie_pkg::OVR_RST;
		end else begin
			dl_stat_q  <= dl_stat_d;
			ovr_stat_q <= ovr_stat_d;
		end
	end

	// Enable registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			dl_en_q  <= hrie_pkg::DL_RST;
			ovr_en_q <= hrie_pkg::OVR_RST;
		end else begin
			dl_en_q  <= dl_en_d;
			ovr_en_q <= ovr_en_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------

	// Built from next values so it tracks the flags in the same cycle
	// A registered output keeps the pin free of decode glitches
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(dl_stat_d & dl_en_d) | (ovr_stat_d & ovr_en_d);
		end
	end

	assign irq             = irq_q;
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Antecedents leave out a status read taken with a new event, as
	// the set wins there and the flag stays up on purpose

	a_irq_tracks_flags: assert property (
		##1 irq_q == (|(dl_stat_q & dl_en_q) | (ovr_stat_q & ovr_en_q)))
		else $error("irq does not match enabled flags");

	a_check_err_irq: assert property (
		rx.check_err && dl_en_q[hrie_pkg::BIT_CHECK_ERR] && !wr_acc
		|=> irq_q && dl_stat_q[hrie_pkg::BIT_CHECK_ERR])
		else $error("check error did not raise interrupt");

	a_abort_seven: assert property (
		(rx.dl_valid && rx.dl_bit)[*7] |=> ones_q == 3'h7)
		else $error("seven ones did not fill the run count");

	a_abort_flag: assert property (
		rx.dl_valid && rx.dl_bit && ones_q == 3'h6
		|=> dl_stat_q[hrie_pkg::BIT_ABORT])
		else $error("seventh one did not set abort flag");

	a_abort_once: assert property (
		ones_q == 3'h7 && !dl_stat_q[hrie_pkg::BIT_ABORT]
		|=> !dl_stat_q[hrie_pkg::BIT_ABORT])
		else $error("long run of ones flagged abort again");

	a_flag_detect: assert property (
		rx.dl_valid && ({rx.dl_bit, shift_q[7:1]} == 8'h7E)
		|=> dl_stat_q[hrie_pkg::BIT_FLAG] && count_q == 9'h000)
		else $error("flag octet not detected");

	a_flag_irq: assert property (
		rx.dl_valid && ({rx.dl_bit, shift_q[7:1]} == 8'h7E)
		&& dl_en_q[hrie_pkg::BIT_FLAG] && !wr_acc |=> irq_q)
		else $error("enabled flag octet did not raise interrupt");

	a_oversize_set: assert property (
		rx.byte_stb && count_q == 9'h114 && !flag_ev
		|=> ovr_stat_q && count_q == 9'h115)
		else $error("oversize flag not set at byte 277");

	a_oversize_hold: assert property (
		ovr_stat_q && !(rd_acc && avs_address == hrie_pkg::ADDR_OVR_STAT)
		|=> ovr_stat_q)
		else $error("oversize flag dropped without read");

	a_oversize_clear: assert property (
		rd_acc && avs_address == hrie_pkg::ADDR_OVR_STAT && !ovr_ev
		&& avs_readdata[0] |=> !ovr_stat_q)
		else $error("oversize flag not cleared by read");

	a_status_no_write: assert property (
		wr_acc && avs_address == hrie_pkg::ADDR_OVR_STAT && !ovr_ev
		|=> ovr_stat_q == $past(ovr_stat_q))
		else $error("write changed the oversize flag");

	a_oversize_gate: assert property (
		!ovr_en_q && dl_en_q == 3'h0 && !wr_acc |=> !irq_q)
		else $error("masked oversize raised interrupt");

	a_ovr_en_write: assert property (
		wr_acc && avs_address == hrie_pkg::ADDR_OVR_EN
		|=> ovr_en_q == $past(avs_writedata[hrie_pkg::BIT_OVERSIZE]))
		else $error("oversize enable write not stored");

	a_dl_read_clear: assert property (
		rd_acc && avs_address == hrie_pkg::ADDR_DL_STAT && dl_ev == 3'h0
		|=> (dl_stat_q & $past(avs_readdata[2:0])) == 3'h0)
		else $error("data-link flags not cleared by read");

	a_wait_one_cycle: assert property (
		req && wait_q |=> !wait_q ##1 wait_q)
		else $error("waitrequest not low for one cycle");

	a_rdata_high: assert property (
		!avs_waitrequest |-> avs_readdata[31:3] == 29'h0)
		else $error("read data bits above the fields not zero");

	// Scenarios the bench is meant to reach
	c_oversize_irq: cover property (ovr_ev && ovr_en_q ##1 irq_q);
	c_abort_irq: cover property (
		abort_ev && dl_en_q[hrie_pkg::BIT_ABORT] ##1 irq_q);
	c_flag_irq: cover property (
		flag_ev && dl_en_q[hrie_pkg::BIT_FLAG] ##1 irq_q);
	c_read_clear: cover property (rd_acc &&
		avs_address == hrie_pkg::ADDR_DL_STAT && rdata_q != 32'h0000_0000);
	c_set_on_clear: cover property (
		rd_acc && avs_address == hrie_pkg::ADDR_OVR_STAT && ovr_ev);

endmodule

// [bench/hrie_rx_src.sv]
/*
 * Far-side model of the receive data-link path: shifts one octet
 * onto the serial data-link bit, LSB first, one bit per cycle.
 * Assumes the receive path shares mclk with the register port.
 */
`timescale 1ns/10ps
module hrie_rx_src (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [7:0] octet,
	output logic            dl_bit,
	output logic            dl_valid
);
	logic [7:0] sh_q;
	logic [3:0] n_q;

	// Load on go, then shift; count of bits still to send
	always_ff @(posedge mclk) begin
		if (rst) begin
			sh_q <= 8'h00;
			n_q  <= 4'h0;
		end else if (go) begin
			sh_q <= octet;
			n_q  <= 4'h8;
		end else if (n_q != 4'h0) begin
			sh_q <= sh_q >> 1;
			n_q  <= n_q - 4'h1;
		end
	end

	// Idle line shows the inverse bit so a stale value never helps
	assign dl_valid = (n_q != 4'h0);
	assign dl_bit   = dl_valid ? sh_q[0] : ~sh_q[0];
endmodule

// [bench/hrie_irq_tb.sv]
/*
 * Self-checking bench of the data-link interrupt block: an
 * Avalon-MM master, a serial source and an integer model.
 * Assumes one 100 MHz clock and a synchronous reset.
 */
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module hrie_irq_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [13:0] addr = 14'h0000;
	logic rd_q = 1'b0;
	logic wr_q = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic wait_q;
	logic irq;
	logic go = 1'b0;
	logic [7:0] oct = 8'h00;
	logic sb, sv;
	logic stb = 1'b0;
	logic ce = 1'b0;
	logic [31:0] q;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int m_st, m_en, m_ov, m_oe, k, e, r;
	hrie_pkg::hrie_rx_t rx;

	// ----------------------------------------------------------------
	// Clock, design and far side
	// ----------------------------------------------------------------
	always #5 mclk = ~mclk;
	assign rx = {sb, sv, stb, ce};

	hrie_irq dut (.mclk(mclk), .rst(rst), .avs_address(addr),
		.avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wait_q), .rx(rx), .irq(irq));
	hrie_rx_src src (.mclk(mclk), .rst(rst), .go(go), .octet(oct),
		.dl_bit(sb), .dl_valid(sv));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hold the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [13:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		rd_q <= ~w;
		wr_q <= w;
		addr <= a;
		wd   <= d;
		do @(posedge mclk); while (wait_q !== 1'b0);
		q = rdata;
		rd_q <= 1'b0;
		wr_q <= 1'b0;
	endtask

	task automatic send(input logic [7:0] o);
		@(posedge mclk);
		go  <= 1'b1;
		oct <= o;
		@(posedge mclk);
		go  <= 1'b0;
		repeat (10) @(posedge mclk);
	endtask

	task automatic chk_irq;
		#1 `CHK("irq", ((m_st & m_en) != 0 || (m_ov & m_oe) != 0), irq)
	endtask

	// Cut a hang short
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			test_done;
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hD8AD));
		{m_st, m_en, m_ov, m_oe} = '0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		// Reset values and an unmapped address all read zero
		for (k = 0; k < 5; k++) begin
			bus(1'b0, hrie_pkg::ADDR_DL_STAT + 14'(4 * k), 32'h0);
			`CHK("reset", 32'h0, q)
		end
		// Status registers ignore writes
		bus(1'b1, hrie_pkg::ADDR_OVR_STAT, 32'hFFFF_FFFF);
		bus(1'b0, hrie_pkg::ADDR_OVR_STAT, 32'h0);
		`CHK("ovr_stat_wr", 32'h0, q)
		bus(1'b1, hrie_pkg::ADDR_DL_STAT, 32'hFFFF_FFFF);
		bus(1'b0, hrie_pkg::ADDR_DL_STAT, 32'h0);
		`CHK("dl_stat_wr", 32'h0, q)
		$display("test reset done");
		// Random enable pattern reads back in the low three bits
		r = $urandom;
		bus(1'b1, hrie_pkg::ADDR_DL_EN, r);
		bus(1'b0, hrie_pkg::ADDR_DL_EN, 32'h0);
		`CHK("enable", {29'h0, r[2:0]}, q)
		// A write without the low byte lane leaves the enables alone
		be <= 4'hE;
		bus(1'b1, hrie_pkg::ADDR_DL_EN, ~r);
		be <= 4'hF;
		bus(1'b0, hrie_pkg::ADDR_DL_EN, 32'h0);
		`CHK("enable_be", {29'h0, r[2:0]}, q)
		$display("test enable done");
		// Each event with its enable off, then on
		for (e = 0; e < 2; e++) begin
			for (k = 2; k >= 0; k--) begin
				m_en = e ? 7 : 0;
				bus(1'b1, hrie_pkg::ADDR_DL_EN, m_en);
				if (k == 2) begin
					@(posedge mclk) ce <= 1'b1;
					@(posedge mclk) ce <= 1'b0;
					@(posedge mclk);
				end else
					send(k == 1 ? 8'hFF : hrie_pkg::FLAG_OCTET);
				m_st = 1 << k;
				chk_irq();
				bus(1'b0, hrie_pkg::ADDR_DL_STAT, 32'h0);
				`CHK("status", m_st, q)
				m_st = 0;
				chk_irq();
			end
		end
		$display("test events done");
		// Oversize boundary at 276 and 277 bytes, enable on then off
		m_en = 0;
		bus(1'b1, hrie_pkg::ADDR_DL_EN, 32'h0);
		for (e = 1; e >= 0; e--) begin
			m_oe = e;
			bus(1'b1, hrie_pkg::ADDR_OVR_EN, e);
			bus(1'b0, hrie_pkg::ADDR_OVR_EN, 32'h0);
			`CHK("ovr_en", e, q)
			send(hrie_pkg::FLAG_OCTET);
			repeat (hrie_pkg::MAX_MSG_BYTES) @(posedge mclk) stb <= 1'b1;
			@(posedge mclk) stb <= 1'b0;
			bus(1'b0, hrie_pkg::ADDR_OVR_STAT, 32'h0);
			`CHK("ovr_276", 32'h0, q)
			@(posedge mclk) stb <= 1'b1;
			@(posedge mclk) stb <= 1'b0;
			m_ov = 1;
			repeat (3) @(posedge mclk);
			chk_irq();
			repeat (20) @(posedge mclk);
			chk_irq();
			bus(1'b0, hrie_pkg::ADDR_OVR_STAT, 32'h0);
			`CHK("ovr_277", 32'h1, q)
			m_ov = 0;
			chk_irq();
			bus(1'b0, hrie_pkg::ADDR_OVR_STAT, 32'h0);
			`CHK("ovr_clr", 32'h0, q)
			bus(1'b0, hrie_pkg::ADDR_DL_STAT, 32'h0);
			`CHK("flag", 32'h1, q)
		end
		$display("test oversize done");
		test_done;
	end
endmodule
